// ==== logic/dac_link_pkg.sv ====
/*
  Shared constants for the three-wire converter word link.
  Assumes both ends run on a 10 MHz system clock.
*/
package dac_link_pkg;
  localparam int          FRAME_BITS   = 16;
  localparam int          CODE_BITS    = 14;
  localparam int          SUB_BITS     = 2;
  localparam int          CLK_SYS_NS   = 100;
  localparam int          SCLK_HALF_NS = 400;
  localparam int          HALF_CYCLES  = SCLK_HALF_NS / CLK_SYS_NS;
  localparam int          FIFO_DEPTH   = 16;
  localparam logic [13:0] LATCH_RESET  = 14'h0000;
  localparam logic [1:0]  SUB_ZERO     = 2'h0;
endpackage

// ==== logic/dac_link_if.sv ====
/*
  Three-wire link between the host serial controller and the converter end.
  Assumes the bench joins the host and device modports.
*/
interface dac_link_if;
  logic sel_n;
  logic sclk;
  logic sdata;
  modport host   (output sel_n, output sclk, output sdata);
  modport device (input sel_n, input sclk, input sdata);
endinterface

// ==== logic/word_fifo.sv ====
/*
  Parameterised first-in first-out buffer with valid/ready on both sides.
  Assumes a single clock and synchronous reset.
*/
module word_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          rdy;
  } fifo_t;
  fifo_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;

  // Ready is held in a register so the refusal seen by the user comes straight from a flip-flop.
  assign in_ready  = s_q.rdy;
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem_q[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q     <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
    if (push) begin
      mem_q[s_q.wp] <= in_data;
    end
  end
endmodule

// ==== logic/dac_host.sv ====
/*
  Host end: buffers 14-bit codes and sends each as one 16-bit frame.
  Assumes the device end samples data on rising shift clock edges.
*/
module dac_host (
  // Clock and reset.
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  // User side.
  input  wire logic                            code_valid,
  output logic                                 code_ready,
  input  wire logic [dac_link_pkg::CODE_BITS-1:0] code_data,
  output logic                                 busy,
  // Link.
  dac_link_if.host                             link
);
  import dac_link_pkg::*;
  typedef enum {IDLE, SETUP, LOW, HIGH, FINISH} st_t;
  typedef struct packed {
    st_t                   st;
    logic [15:0]           sh;
    logic [4:0]            bits;
    logic [3:0]            div;
    logic                  sel_n;
    logic                  sclk;
    logic                  sdata;
    logic                  busy;
  } host_t;
  host_t s_q, s_d;
  logic                 f_valid, f_ready;
  logic [CODE_BITS-1:0] f_data;

  word_fifo #(.WIDTH(CODE_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (code_valid),
    .in_ready  (code_ready),
    .in_data   (code_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign f_ready = (s_q.st == IDLE);

  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + 4'h1;
    case (s_q.st)
      IDLE: begin
        s_d.sel_n = 1'b1;
        s_d.sclk  = 1'b0;
        s_d.busy  = f_valid;
        if (f_valid) begin
          s_d.sh    = {f_data, SUB_ZERO};
          s_d.bits  = 5'(FRAME_BITS);
          s_d.sel_n = 1'b0;
          s_d.div   = 4'h0;
          s_d.st    = SETUP;
        end
      end
      SETUP, LOW: begin
        s_d.sdata = s_q.sh[15];
        if (s_q.div == 4'(HALF_CYCLES - 1)) begin
          s_d.div  = 4'h0;
          s_d.sclk = 1'b1;
          s_d.sh   = {s_q.sh[14:0], 1'b0};
          s_d.bits = s_q.bits - 5'h1;
          s_d.st   = HIGH;
        end
      end
      HIGH: begin
        if (s_q.div == 4'(HALF_CYCLES - 1)) begin
          s_d.div  = 4'h0;
          s_d.sclk = 1'b0;
          s_d.st   = (s_q.bits == 5'h0) ? FINISH : LOW;
        end
      end
      FINISH: begin
        if (s_q.div == 4'(HALF_CYCLES - 1)) begin
          s_d.sel_n = 1'b1;
          s_d.st    = IDLE;
        end
      end
      default: s_d.st = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q       <= '0;
      s_q.st    <= IDLE;
      s_q.sel_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sel_n = s_q.sel_n;
  assign link.sclk  = s_q.sclk;
  assign link.sdata = s_q.sdata;
  assign busy       = s_q.busy;
endmodule

// ==== logic/dac_device.sv ====
/*
  Device end: samples the three-wire link and updates the converter latch.
  Assumes link pins are asynchronous to clk_sys; rst stands in for power-on.
*/
module dac_device (
  // Clock and reset.
  input  wire logic                               clk_sys,
  input  wire logic                               rst,
  // Link.
  dac_link_if.device                              link,
  // Converter side.
  output logic [dac_link_pkg::CODE_BITS-1:0]      latch_code,
  output logic                                    latch_strobe,
  output logic                                    frame_short
);
  import dac_link_pkg::*;
  typedef struct packed {
    logic [1:0]            sel_s;
    logic [1:0]            clk_s;
    logic [1:0]            dat_s;
    logic                  sel_prev;
    logic                  clk_prev;
    logic [15:0]           sh;
    logic [4:0]            cnt;
    logic [CODE_BITS-1:0]  latch;
    logic                  strobe;
    logic                  short_f;
  } dev_t;
  dev_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.sel_s    = {s_q.sel_s[0], link.sel_n};
    s_d.clk_s    = {s_q.clk_s[0], link.sclk};
    s_d.dat_s    = {s_q.dat_s[0], link.sdata};
    s_d.sel_prev = s_q.sel_s[1];
    s_d.clk_prev = s_q.clk_s[1];
    s_d.strobe   = 1'b0;
    if (s_q.sel_prev && !s_q.sel_s[1]) begin
      s_d.cnt = 5'h0;
    end
    if (!s_q.sel_s[1] && s_q.clk_s[1] && !s_q.clk_prev) begin
      s_d.sh = {s_q.sh[14:0], s_q.dat_s[1]};
      if (s_q.cnt != 5'h1f) begin
        s_d.cnt = s_q.cnt + 5'h1;
      end
    end
    if (!s_q.sel_prev && s_q.sel_s[1]) begin
      s_d.latch   = s_q.sh[15:SUB_BITS];
      s_d.strobe  = 1'b1;
      s_d.short_f = (s_q.cnt != 5'(FRAME_BITS));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q          <= '0;
      s_q.sel_s    <= 2'h3;
      s_q.sel_prev <= 1'b1;
      s_q.latch    <= LATCH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign latch_code   = s_q.latch;
  assign latch_strobe = s_q.strobe;
  assign frame_short  = s_q.short_f;
endmodule

// ==== verification/dac_link_sva.sv ====
/* Wire checks for the three-wire converter link.
   Assumes it watches the host-to-device link on clk_sys. */
module dac_link_sva (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Link.
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sclk_q;
  logic [4:0] rises_q;
  always_ff @(posedge clk_sys) begin
    sclk_q  <= sclk;
    rises_q <= (rst || sel_n) ? 5'h00 : rises_q + 5'(sclk && !sclk_q);
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_idle_clk_low: assert property (sel_n |-> !sclk) else $error("clock outside frame");
  chk_select_lead: assert property ($fell(sel_n) |-> !sclk[*3]) else $error("early clock");
  chk_data_setup: assert property ($rose(sclk) |-> $stable(sdata)) else $error("data moved");
  chk_high_phase: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("high phase");
  chk_low_phase: assert property ($fell(sclk) |-> !sclk[*4]) else $error("low phase");
  chk_bit_count: assert property ($rose(sel_n) |-> rises_q == 5'h10) else $error("bit count");
  chk_sub_zero: assert property ($rose(sclk) && rises_q >= 5'h0e |-> !sdata) else $error("sub bit");
  chk_select_held: assert property (!sel_n && rises_q != 5'h10 |=> !sel_n) else $error("cut frame");
  cover property ($rose(sel_n));
  cover property ($rose(sclk) && rises_q == 5'h0f);
  cover property ($rose(sel_n) ##[1:20] $fell(sel_n));
endmodule

// ==== verification/serial_dac_word_loader_tb.sv ====
/* Bench for the converter word link: host and device joined, plus a second
   device driven directly by the bench. Assumes the design files come first. */
module serial_dac_word_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dac_link_pkg::*;
  logic                 clk_sys    = 0;
  logic                 rst        = 1;
  logic                 code_valid = 0;
  logic                 code_ready, busy, strobe, fs, fs2;
  logic [CODE_BITS-1:0] code_data  = '0;
  logic [CODE_BITS-1:0] lc, lc2;
  logic [CODE_BITS-1:0] got[$];
  int                   bad_count  = 0;
  int                   n_compared = 0;
  dac_link_if link_a ();
  dac_link_if link_b ();
  dac_host dac_host_inst (.clk_sys(clk_sys), .rst(rst), .code_valid(code_valid), .code_ready(code_ready),
    .code_data(code_data), .busy(busy), .link(link_a.host));
  dac_device dac_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link_a.device), .latch_code(lc),
    .latch_strobe(strobe), .frame_short(fs));
  dac_device dac_device_inst_b (.clk_sys(clk_sys), .rst(rst), .link(link_b.device), .latch_code(lc2),
    .latch_strobe(), .frame_short(fs2));
  dac_link_sva dac_link_sva_inst (.clk_sys(clk_sys), .rst(rst), .sel_n(link_a.sel_n), .sclk(link_a.sclk),
    .sdata(link_a.sdata));
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (strobe === 1'b1) got.push_back(lc);
  function automatic logic [CODE_BITS-1:0] w(input int i);
    return 14'(i * 16'h0a5b + 16'h3fff);
  endfunction
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [CODE_BITS-1:0] a, input logic [CODE_BITS-1:0] e);
    n_compared++;
    if (a !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 40000 && got.size() < n; i++) @(posedge clk_sys);
    #1;
    if (got.size() < n) begin
      bad_count++;
      $display("CHECK FAILED %0t: no latch update", $time);
      end_sim();
    end
  endtask
  // Pushes twenty codes back to back so the buffer fills and refuses.
  task automatic run_stream();
    logic seen_full;
    seen_full = 0;
    got.delete();
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < 20; i++) begin
      code_valid = 1;
      code_data  = w(i);
      for (int k = 0; k < 900 && code_ready !== 1'b1; k++) begin
        seen_full = 1;
        @(posedge clk_sys);
        #1;
      end
      if (code_ready !== 1'b1) begin
        bad_count++;
        $display("CHECK FAILED %0t: buffer never ready", $time);
        end_sim();
      end
      @(posedge clk_sys);
      #1;
    end
    code_valid = 0;
    cmp({13'h0, busy}, 14'h0001);
    wait_got(20);
    for (int i = 0; i < 20; i++) cmp(got[i], w(i));
    cmp({13'h0, busy}, 14'h0000);
    cmp({13'h0, seen_full}, 14'h0001);
    cmp({13'h0, fs}, 14'h0000);
  endtask
  task automatic drive_b(input logic [15:0] v, input int n);
    link_b.sel_n = 0;
    for (int b = 15; b > 15 - n; b--) begin
      link_b.sdata = v[b];
      #400 link_b.sclk = 1;
      #400 link_b.sclk = 0;
    end
    #400 link_b.sel_n = 1;
    link_b.sdata = ~link_b.sdata;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  // A cut frame is flagged, then a full frame loads the latch.
  task automatic run_cut_frame();
    drive_b(16'ha5a4, 8);
    cmp({13'h0, fs2}, 14'h0001);
    drive_b({14'h1234, SUB_ZERO}, 16);
    cmp(lc2, 14'h1234);
    cmp({13'h0, fs2}, 14'h0000);
  endtask
  initial begin
    link_b.sel_n = 1;
    link_b.sclk  = 0;
    link_b.sdata = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst = 0;
    @(posedge clk_sys);
    #1;
    cmp(lc, LATCH_RESET);
    run_stream();
    rst = 1;
    repeat (2) @(posedge clk_sys);
    #1 rst = 0;
    cmp(lc, LATCH_RESET);
    run_cut_frame();
    end_sim();
  end
endmodule
